// *** hdl/rrc_defs.svh ***
// Offsets, field positions, reset values and codes of the event and ring control register bank.
`ifndef RRC_DEFS_SVH
`define RRC_DEFS_SVH

`define RRC_EVT_W           11
`define RRC_EVT_W_MAX       16

`define RRC_IDX_EVT_EN      6'h1C
`define RRC_IDX_EVT_PEND    6'h1D
`define RRC_IDX_RING_CTL    6'h1E
`define RRC_IDX_PAGE_SEL    6'h1F
`define RRC_IDX_EVT_CLR     6'h20

`define RRC_PAGE_MAIN       16'h0000
`define RRC_PAGE_EXT        16'h0002
`define RRC_WORD_ZERO       16'h0000

`define RRC_EVT_MEM_RING    10
`define RRC_EVT_SEC_EGR     9
`define RRC_EVT_SEC_ING     8
`define RRC_EVT_SEC_FCBUF   7
`define RRC_EVT_LINE_MAC    6
`define RRC_EVT_HOST_MAC    5
`define RRC_EVT_SWAP_DONE   4
`define RRC_EVT_EEE_FAIL    3
`define RRC_EVT_RX_QUIET    2
`define RRC_EVT_RX_SLEEP    1
`define RRC_EVT_WAKE_ERR    0

`define RRC_RING_STARTUP    15
`define RRC_RING_ADV        14
`define RRC_RING_LP_ADV     13
`define RRC_RING_FORCE      12
`define RRC_RING_STAT_HI    5
`define RRC_RING_STAT_LO    4
`define RRC_RING_START      0

`define RRC_HRESP_OKAY      1'b0

`endif

// *** hdl/rrc_pkg.sv ***
// Types shared by the event and ring control register bank.
package rrc_pkg;

    // Codes match the two-bit ring resiliency status field.
    typedef enum logic [1:0] {
        RRC_SLAVE     = 2'b00,
        RRC_M2S       = 2'b01,
        RRC_S2M       = 2'b10,
        RRC_MASTER    = 2'b11
    } rrc_role_t;

endpackage : rrc_pkg

// *** hdl/rrc_role_fsm.sv ***
// Timing role tracker and switchover sequencer for ring resiliency.
`timescale 1ns/10ps
`default_nettype none
module rrc_role_fsm
    import rrc_pkg::*;
(
    input  wire logic      i_sys_clk,
    input  wire logic      i_rst_n,
    input  wire logic      i_link_up,
    input  wire logic      i_an_master,
    input  wire logic      i_start,
    input  wire logic      i_swap_done,
    output var  rrc_role_t o_role,
    output var  logic      o_swap_req,
    output var  logic      o_done
);

    rrc_role_t role_reg;
    logic      link_prev_reg;
    logic      seen_reg;
    logic      first_up;
    logic      busy;

    assign first_up = i_link_up && !link_prev_reg && !seen_reg;
    assign busy     = (role_reg == RRC_S2M) || (role_reg == RRC_M2S);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            link_prev_reg <= 1'b0;
            seen_reg      <= 1'b0;
        end else begin
            link_prev_reg <= i_link_up;
            if (first_up) begin
                seen_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            role_reg <= RRC_SLAVE;
        end else begin
            unique case (role_reg)
                RRC_SLAVE, RRC_MASTER: begin
                    if (first_up) begin
                        role_reg <= i_an_master ? RRC_MASTER : RRC_SLAVE;
                    end else if (i_start) begin
                        role_reg <= (role_reg == RRC_SLAVE) ? RRC_S2M : RRC_M2S;
                    end
                end
                RRC_S2M: begin
                    if (i_swap_done) begin
                        role_reg <= RRC_MASTER;
                    end
                end
                RRC_M2S: begin
                    if (i_swap_done) begin
                        role_reg <= RRC_SLAVE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_swap_req <= 1'b0;
            o_done     <= 1'b0;
        end else begin
            o_done     <= busy && i_swap_done;
            o_swap_req <= busy ? !i_swap_done : (i_start && !first_up);
        end
    end

    assign o_role = role_reg;

    a_swap_finish: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (role_reg == RRC_S2M && i_swap_done) |=> (role_reg == RRC_MASTER) && o_done)
        else $error("Slave to master switchover did not finish as master.");

    a_start_enter: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (role_reg == RRC_MASTER && i_start && !first_up) |=> (role_reg == RRC_M2S) && o_swap_req)
        else $error("Start from master did not enter master to slave.");

endmodule : rrc_role_fsm
`default_nettype wire

// *** hdl/rrc_regs.sv ***
// AHB-Lite register bank for extended events and ring resiliency control.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rrc_defs.svh"
module rrc_regs
    import rrc_pkg::*;
#(
    parameter int EVT_W = `RRC_EVT_W
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output var  logic        o_hreadyout,
    output var  logic [31:0] o_hrdata,
    output var  logic        o_hresp,
    input  wire logic        i_mem_ring_evt,
    input  wire logic        i_sec_egress_evt,
    input  wire logic        i_sec_ingress_evt,
    input  wire logic        i_sec_fcbuf_evt,
    input  wire logic        i_line_mac_evt,
    input  wire logic        i_host_mac_evt,
    input  wire logic        i_eee_link_fail_evt,
    input  wire logic        i_rx_quiet_timer_evt,
    input  wire logic        i_rx_sleep_timer_evt,
    input  wire logic        i_eee_wake_err_evt,
    input  wire logic        i_link_up,
    input  wire logic        i_an_master,
    input  wire logic        i_link_partner_ring_adv,
    input  wire logic        i_swap_done,
    output var  logic        o_irq,
    output var  logic        o_ring_startup_en,
    output var  logic        o_ring_adv,
    output var  logic        o_ring_force_en,
    output var  logic        o_swap_req
);

    if (EVT_W < `RRC_EVT_W || EVT_W > `RRC_EVT_W_MAX) begin : g_check_evt_w
        $error("EVT_W must lie between 11 and 16.");
    end

    logic [15:0]      page_reg;
    logic [EVT_W-1:0] en_reg;
    logic [EVT_W-1:0] pend_reg;
    logic             startup_reg;
    logic             adv_reg;
    logic             lp_adv_reg;
    logic             force_reg;
    logic             start_reg;
    logic             wr_pend_reg;
    logic [5:0]       wr_idx_reg;

    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] clr_mask;
    logic [5:0]       acc_idx;
    logic             addr_ph;
    logic             acc_hit;
    logic             rd_clear;
    logic             wr_clear;
    logic [15:0]      wdata;
    logic             ring_on;
    logic             start_ok;
    rrc_role_t        role;
    logic             fsm_swap_req;
    logic             fsm_done;

    function automatic logic reg_visible(input logic [5:0] idx, input logic [15:0] page);
        logic ext;
        ext = (idx >= `RRC_IDX_EVT_EN) && (idx <= `RRC_IDX_RING_CTL);
        reg_visible = (idx == `RRC_IDX_PAGE_SEL) || (idx == `RRC_IDX_EVT_CLR)
                      || (ext && (page == `RRC_PAGE_EXT));
    endfunction : reg_visible

    function automatic logic [15:0] ring_word();
        logic [15:0] w;
        w                                        = `RRC_WORD_ZERO;
        w[`RRC_RING_STARTUP]                     = startup_reg;
        w[`RRC_RING_ADV]                         = adv_reg;
        w[`RRC_RING_LP_ADV]                      = lp_adv_reg;
        w[`RRC_RING_FORCE]                       = force_reg;
        w[`RRC_RING_STAT_HI:`RRC_RING_STAT_LO]   = role;
        w[`RRC_RING_START]                       = start_reg;
        ring_word                                = w;
    endfunction : ring_word

    function automatic logic [15:0] read_word(input logic [5:0] idx);
        logic [15:0] w;
        w = `RRC_WORD_ZERO;
        unique case (idx)
            `RRC_IDX_EVT_EN:   w = 16'(en_reg);
            `RRC_IDX_EVT_PEND: w = 16'(pend_reg);
            `RRC_IDX_RING_CTL: w = ring_word();
            `RRC_IDX_PAGE_SEL: w = page_reg;
            default:           w = `RRC_WORD_ZERO;
        endcase
        read_word = w;
    endfunction : read_word

    assign addr_ph  = i_hsel && i_htrans[1] && i_hready;
    assign acc_idx  = i_haddr[7:2];
    assign acc_hit  = addr_ph && (i_haddr[31:8] == 24'h000000) && (i_haddr[1:0] == 2'b00)
                      && reg_visible(acc_idx, page_reg);
    assign rd_clear = acc_hit && !i_hwrite && (acc_idx == `RRC_IDX_EVT_PEND);
    assign wdata    = i_hwdata[15:0];
    assign wr_clear = wr_pend_reg && (wr_idx_reg == `RRC_IDX_EVT_CLR);
    assign ring_on  = force_reg || (adv_reg && lp_adv_reg);
    assign start_ok = start_reg && ring_on;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 6'h00;
        end else begin
            wr_pend_reg <= acc_hit && i_hwrite;
            if (addr_ph) begin
                wr_idx_reg <= acc_idx;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_hrdata    <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp     <= `RRC_HRESP_OKAY;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= `RRC_HRESP_OKAY;
            if (addr_ph) begin
                o_hrdata <= (acc_hit && !i_hwrite) ? {16'h0000, read_word(acc_idx)} : 32'h00000000;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            page_reg <= `RRC_PAGE_MAIN;
        end else if (wr_pend_reg && (wr_idx_reg == `RRC_IDX_PAGE_SEL)) begin
            page_reg <= wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            en_reg <= '0;
        end else if (wr_pend_reg && (wr_idx_reg == `RRC_IDX_EVT_EN)) begin
            en_reg <= wdata[EVT_W-1:0];
        end
    end

    always_comb begin
        evt_set                     = '0;
        evt_set[`RRC_EVT_MEM_RING]  = i_mem_ring_evt;
        evt_set[`RRC_EVT_SEC_EGR]   = i_sec_egress_evt;
        evt_set[`RRC_EVT_SEC_ING]   = i_sec_ingress_evt;
        evt_set[`RRC_EVT_SEC_FCBUF] = i_sec_fcbuf_evt;
        evt_set[`RRC_EVT_LINE_MAC]  = i_line_mac_evt;
        evt_set[`RRC_EVT_HOST_MAC]  = i_host_mac_evt;
        evt_set[`RRC_EVT_SWAP_DONE] = fsm_done;
        evt_set[`RRC_EVT_EEE_FAIL]  = i_eee_link_fail_evt;
        evt_set[`RRC_EVT_RX_QUIET]  = i_rx_quiet_timer_evt;
        evt_set[`RRC_EVT_RX_SLEEP]  = i_rx_sleep_timer_evt;
        evt_set[`RRC_EVT_WAKE_ERR]  = i_eee_wake_err_evt;
    end

    always_comb begin
        clr_mask = '0;
        if (rd_clear) begin
            clr_mask = '1;
        end
        if (wr_clear) begin
            clr_mask = clr_mask | wdata[EVT_W-1:0];
        end
    end

    // A new event in the clearing cycle stays pending.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~clr_mask) | evt_set;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((pend_reg & ~clr_mask) | evt_set) & en_reg);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            startup_reg <= 1'b0;
            adv_reg     <= 1'b0;
            force_reg   <= 1'b0;
        end else if (wr_pend_reg && (wr_idx_reg == `RRC_IDX_RING_CTL)) begin
            startup_reg <= wdata[`RRC_RING_STARTUP];
            adv_reg     <= wdata[`RRC_RING_ADV];
            force_reg   <= wdata[`RRC_RING_FORCE];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            lp_adv_reg <= 1'b0;
        end else begin
            lp_adv_reg <= i_link_partner_ring_adv;
        end
    end

    // The start bit lives one cycle: taken by the sequencer or dropped.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= wr_pend_reg && (wr_idx_reg == `RRC_IDX_RING_CTL)
                         && wdata[`RRC_RING_START]
                         && (role == RRC_SLAVE || role == RRC_MASTER);
        end
    end

    rrc_role_fsm u_role_fsm (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_link_up   (i_link_up),
        .i_an_master (i_an_master),
        .i_start     (start_ok),
        .i_swap_done (i_swap_done),
        .o_role      (role),
        .o_swap_req  (fsm_swap_req),
        .o_done      (fsm_done)
    );

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_ring_startup_en <= 1'b0;
            o_ring_adv        <= 1'b0;
            o_ring_force_en   <= 1'b0;
            o_swap_req        <= 1'b0;
        end else begin
            o_ring_startup_en <= startup_reg;
            o_ring_adv        <= adv_reg;
            o_ring_force_en   <= force_reg;
            o_swap_req        <= fsm_swap_req;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_en_write: assert property (
        (wr_pend_reg && wr_idx_reg == `RRC_IDX_EVT_EN) |=> (en_reg == $past(wdata[EVT_W-1:0])))
        else $error("Enable register did not take written data.");

    a_read_clears: assert property (
        (rd_clear && !wr_clear && evt_set == '0) |=> (pend_reg == '0))
        else $error("Pending bits survived a read of the pending register.");

    a_set_wins: assert property (
        (evt_set[`RRC_EVT_MEM_RING]) |=> pend_reg[`RRC_EVT_MEM_RING])
        else $error("Memory integrity event lost.");

    a_swap_pends: assert property (
        fsm_done |=> pend_reg[`RRC_EVT_SWAP_DONE])
        else $error("Switchover completion did not pend bit 4.");

    a_irq_level: assert property (
        (|(pend_reg & en_reg) && !rd_clear && !wr_clear) |=> o_irq)
        else $error("Interrupt low while an enabled bit is pending.");

    a_irq_masked: assert property (
        (en_reg == '0) |=> !o_irq)
        else $error("Interrupt high with every enable bit clear.");

    a_start_selfclr: assert property (
        start_reg && !(wr_pend_reg && wr_idx_reg == `RRC_IDX_RING_CTL && wdata[`RRC_RING_START])
        |=> !start_reg)
        else $error("Start bit did not clear itself.");

    a_start_refused: assert property (
        (role == RRC_S2M || role == RRC_M2S) |=> !start_reg)
        else $error("Start bit set while a switchover was in progress.");

    a_ring_write: assert property (
        (wr_pend_reg && wr_idx_reg == `RRC_IDX_RING_CTL) |=> ##1
        (o_ring_force_en == $past(wdata[`RRC_RING_FORCE], 2)))
        else $error("Force enable output did not follow the ring register write.");

    a_page_gate: assert property (
        (addr_ph && page_reg != `RRC_PAGE_EXT && acc_idx == `RRC_IDX_EVT_EN) |-> !acc_hit)
        else $error("Extended register reached without the extended page.");

    a_resp_okay: assert property (
        o_hreadyout && (o_hresp == `RRC_HRESP_OKAY))
        else $error("Slave did not answer ready with OKAY.");

    c_irq_rise: cover property (!o_irq ##1 o_irq);
    c_read_clear: cover property (rd_clear && pend_reg != '0);
    c_swap_done: cover property (fsm_done);
    c_start_taken: cover property (start_ok);

endmodule : rrc_regs
`default_nettype wire

// *** tb/test_ext_event_and_ring_control_regs.sv ***
// Self-checking testbench for the event and ring control register bank.
`timescale 1ns/10ps
`default_nettype none
`include "rrc_defs.svh"
module test_ext_event_and_ring_control_regs
    import rrc_pkg::*;
;
    localparam logic [31:0] A_EN   = {24'h0, `RRC_IDX_EVT_EN, 2'b00};
    localparam logic [31:0] A_PEND = {24'h0, `RRC_IDX_EVT_PEND, 2'b00};
    localparam logic [31:0] A_RING = {24'h0, `RRC_IDX_RING_CTL, 2'b00};
    localparam logic [31:0] A_PSEL = {24'h0, `RRC_IDX_PAGE_SEL, 2'b00};
    localparam logic [31:0] A_CLR  = {24'h0, `RRC_IDX_EVT_CLR, 2'b00};
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        hsel      = 1'b0;
    logic        hwrite    = 1'b0;
    logic [1:0]  htrans    = 2'h0;
    logic [31:0] haddr     = 32'h0;
    logic [31:0] hwdata    = 32'h0;
    logic [10:0] evt       = 11'h000;
    logic        link_up   = 1'b0;
    logic        an_master = 1'b0;
    logic        lp_adv    = 1'b0;
    logic        swap_done = 1'b0;
    logic [31:0] seed      = 32'hF007;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        irq;
    logic        st_en;
    logic        adv;
    logic        force_en;
    logic        swap_req;
    int          n_mismatch = 0;
    int          checks     = 0;
    int          cycles     = 0;
    logic [31:0] exp_pend   = 32'h0;
    logic [31:0] v;
    int          bits[10]   = '{10, 9, 8, 7, 6, 5, 3, 2, 1, 0};

    rrc_regs dut (
        .i_sys_clk            (i_sys_clk),
        .i_rst_n              (i_rst_n),
        .i_hsel               (hsel),
        .i_haddr              (haddr),
        .i_htrans             (htrans),
        .i_hwrite             (hwrite),
        .i_hsize              (3'h2),
        .i_hwdata             (hwdata),
        .i_hready             (hreadyout),
        .o_hreadyout          (hreadyout),
        .o_hrdata             (hrdata),
        .o_hresp              (hresp),
        .i_mem_ring_evt       (evt[10]),
        .i_sec_egress_evt     (evt[9]),
        .i_sec_ingress_evt    (evt[8]),
        .i_sec_fcbuf_evt      (evt[7]),
        .i_line_mac_evt       (evt[6]),
        .i_host_mac_evt       (evt[5]),
        .i_eee_link_fail_evt  (evt[3]),
        .i_rx_quiet_timer_evt (evt[2]),
        .i_rx_sleep_timer_evt (evt[1]),
        .i_eee_wake_err_evt   (evt[0]),
        .i_link_up            (link_up),
        .i_an_master          (an_master),
        .i_link_partner_ring_adv (lp_adv),
        .i_swap_done          (swap_done),
        .o_irq                (irq),
        .o_ring_startup_en    (st_en),
        .o_ring_adv           (adv),
        .o_ring_force_en      (force_en),
        .o_swap_req           (swap_req)
    );

    always #50 i_sys_clk = ~i_sys_clk;

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Waits for hready sampled high at a rising edge.
    task automatic wait_rdy();
        do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
    endtask : wait_rdy

    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge i_sys_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(a, 1'b1, d, dummy);
    endtask : wr

    // Reading the pending register empties the model's copy as well.
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] got;
        bus(a, 1'b0, 32'h0, got);
        chk(what, exp, got);
        if (a == A_PEND) exp_pend = 32'h0;
    endtask : rd_chk

    task automatic pulse(input logic [10:0] p);
        @(posedge i_sys_clk);
        evt <= p;
        @(posedge i_sys_clk);
        evt <= 11'h000;
        exp_pend |= {21'h0, p};
        @(negedge i_sys_clk);
    endtask : pulse

    task automatic swap();
        @(posedge i_sys_clk);
        swap_done <= 1'b1;
        @(posedge i_sys_clk);
        swap_done <= 1'b0;
        repeat (4) @(negedge i_sys_clk);
    endtask : swap

    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : idle

    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd_chk(A_PSEL, 32'h0, "page reset");
        wr(A_EN, 32'h7FF);
        rd_chk(A_EN, 32'h0, "hidden enable");
        wr(A_PSEL, 32'(`RRC_PAGE_EXT));
        rd_chk(A_PSEL, 32'(`RRC_PAGE_EXT), "page select");
        rd_chk(A_EN, 32'h0, "enable reset");
        rd_chk(A_PEND, 32'h0, "pending reset");
        rd_chk(A_RING, 32'h0, "ring reset");
        rd_chk(32'h84, 32'h0, "unmapped");
        $display("test page done");
        v = rnd() & 32'h7FF;
        wr(A_EN, v);
        rd_chk(A_EN, v, "enable rw");
        wr(A_PSEL, 32'h3);
        rd_chk(A_EN, 32'h0, "other page");
        wr(A_PSEL, 32'(`RRC_PAGE_EXT));
        wr(A_EN, 32'h0);
        pulse(11'h001);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(A_EN, 32'h1);
        idle(2);
        chk("irq enabled", 32'h1, {31'h0, irq});
        wr(A_CLR, 32'h1);
        idle(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        exp_pend = 32'h0;
        rd_chk(A_PEND, exp_pend, "pending cleared");
        wr(A_EN, 32'h7FF);
        foreach (bits[k]) begin
            pulse(11'(1 << bits[k]));
            chk("irq set", 32'h1, {31'h0, irq});
            rd_chk(A_PEND, exp_pend, "pending bit");
            rd_chk(A_PEND, 32'h0, "pending read clear");
            idle(1);
            chk("irq drop", 32'h0, {31'h0, irq});
        end
        pulse(11'(rnd() & 32'h7EF));
        rd_chk(A_PEND, exp_pend, "pending mix");
        $display("test events done");
        lp_adv <= 1'b1;
        wr(A_RING, 32'hD000);
        idle(3);
        rd_chk(A_RING, 32'hF000, "ring ctl");
        chk("ring outs", 32'h7, {29'h0, st_en, adv, force_en});
        link_up   <= 1'b1;
        an_master <= 1'b1;
        idle(3);
        rd_chk(A_RING, 32'hF030, "role master");
        wr(A_RING, 32'hD001);
        idle(4);
        rd_chk(A_RING, 32'hF010, "master to slave");
        chk("swap req", 32'h1, {31'h0, swap_req});
        wr(A_RING, 32'hD001);
        idle(4);
        rd_chk(A_RING, 32'hF010, "start refused");
        swap();
        chk("swap req off", 32'h0, {31'h0, swap_req});
        rd_chk(A_RING, 32'hF000, "role slave");
        exp_pend = 32'h10;
        chk("irq swap", 32'h1, {31'h0, irq});
        rd_chk(A_PEND, exp_pend, "swap pending");
        wr(A_RING, 32'hD001);
        idle(4);
        rd_chk(A_RING, 32'hF020, "slave to master");
        swap();
        rd_chk(A_RING, 32'hF030, "role master again");
        wr(A_PSEL, 32'(`RRC_PAGE_MAIN));
        rd_chk(A_PSEL, 32'h0, "page main");
        rd_chk(A_EN, 32'h0, "main page enable");
        wr(A_PSEL, 32'(`RRC_PAGE_EXT));
        rd_chk(A_EN, 32'h7FF, "enable kept");
        $display("test ring done");
        complete_run();
    end
endmodule : test_ext_event_and_ring_control_regs
`default_nettype wire
